// ### hdl/asbp_defines.vh
// Constants for the host-side controller of the byte-wide static RAM port.
`ifndef ASBP_DEFINES_VH
`define ASBP_DEFINES_VH

// Geometry: eleven location lines, one byte per location.
`define ASBP_ADDR_W     11
`define ASBP_DATA_W     8

// Clock rate in kHz and the chosen phase lengths in nanoseconds.
`define ASBP_CLK_KHZ    20000
`define ASBP_SETUP_NS   50
`define ASBP_PULSE_NS   150
`define ASBP_HOLD_NS    50
`define ASBP_ACCESS_NS  200

// Least times round up to whole cycles of the 50 ns clock.
`define ASBP_NS2CYC(ns) ((((ns) * `ASBP_CLK_KHZ) + 999999) / 1000000)
`define ASBP_SETUP_CYC  `ASBP_NS2CYC(`ASBP_SETUP_NS)
`define ASBP_PULSE_CYC  `ASBP_NS2CYC(`ASBP_PULSE_NS)
`define ASBP_HOLD_CYC   `ASBP_NS2CYC(`ASBP_HOLD_NS)
`define ASBP_ACCESS_CYC `ASBP_NS2CYC(`ASBP_ACCESS_NS)

// Width of the phase counter.
`define ASBP_CNT_W      4
`define ASBP_CNT_ZERO   4'h0

`endif

// ### hdl/asbp_phase_timer.v
// Down counter that times each phase of a memory cycle.
`timescale 1ns/1ps
`include "asbp_defines.vh"

module asbp_phase_timer (
  input  wire                     clk_in,
  input  wire                     rst_in,
  input  wire                     load_in,
  input  wire [`ASBP_CNT_W-1:0]   count_in,
  output wire                     done_out
);

  reg [`ASBP_CNT_W-1:0] cnt_ff;
  reg [`ASBP_CNT_W-1:0] nxt_cnt;

  // A load starts a phase; the count then falls to zero and stops there.
  always @* begin
    nxt_cnt = cnt_ff;
    if (load_in) begin
      nxt_cnt = count_in;
    end else if (cnt_ff != `ASBP_CNT_ZERO) begin
      nxt_cnt = cnt_ff - 4'h1;
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      cnt_ff <= `ASBP_CNT_ZERO;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Done is seen in the cycle the count reaches one, so a phase loaded with N lasts N cycles.
  // It is not gated by the load, because the sequencer loads on done and would form a loop.
  assign done_out = (cnt_ff == 4'h1);

endmodule

// ### hdl/asbp_host_ctrl.v
// Host controller that runs read and write cycles on an asynchronous byte-wide static RAM.
//
// How it works
// - Read: select, output enable low, write high.
// - Data stored when first strobe rises.
// - Address stable across whole write pulse.
// - Output enable from read, write from write.
`timescale 1ns/1ps
`include "asbp_defines.vh"

module asbp_host_ctrl (
  input  wire                     clk_in,
  input  wire                     rst_in,
  input  wire                     req_valid_in,
  input  wire                     req_write_in,
  input  wire [`ASBP_ADDR_W-1:0]  req_addr_in,
  input  wire [`ASBP_DATA_W-1:0]  req_wdata_in,
  output wire                     req_ready_out,
  output reg                      rsp_valid_out,
  output reg  [`ASBP_DATA_W-1:0]  rsp_rdata_out,
  output reg  [`ASBP_ADDR_W-1:0]  location_lines_out,
  output reg                      chip_sel_n_out,
  output reg                      write_n_out,
  output reg                      out_en_n_out,
  input  wire [`ASBP_DATA_W-1:0]  data_in,
  output reg  [`ASBP_DATA_W-1:0]  data_out,
  output reg                      data_oe_n_out
);

  // Cycle shapes, counted in clock edges from the edge that takes the request:
  //   Read : edge 0 drives the address with select and output enable low; the bus
  //          is sampled at edge 4, where both strobes lift and the answer pulses.
  //   Write: edge 0 drives address and data with both strobes high; edge 1 drops
  //          select and write together; edge 4 lifts write while select, address
  //          and data still stand; edge 5 lifts select, frees the bus and answers.
  // Dropping both strobes on one edge keeps the device drivers off for the whole
  // write, so the bus never carries two drivers. The price is one setup cycle
  // ahead of every write, which a read does not pay.
  //
  // Phase states: a read needs one timed phase, a write needs three.
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_SETUP = 3'h1;
  localparam [2:0] ST_PULSE = 3'h2;
  localparam [2:0] ST_HOLD  = 3'h3;
  localparam [2:0] ST_READ  = 3'h4;

  // Sequencer state, the kind of cycle in flight and the phase timer handshake.
  reg [2:0]              state_ff;
  reg [2:0]              nxt_state;
  reg                    is_write_ff;
  reg                    nxt_is_write;
  reg                    load;
  reg [`ASBP_CNT_W-1:0]  load_cnt;
  wire                   phase_done;
  wire                   cycle_end;

  // Converts a cycle count from the header to the counter width.
  function [`ASBP_CNT_W-1:0] cyc;
    input integer n;
    begin
      cyc = n[`ASBP_CNT_W-1:0];
    end
  endfunction

  // One shared timer serves every phase, since only one phase runs at a time.
  asbp_phase_timer u_timer (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .load_in  (load),
    .count_in (load_cnt),
    .done_out (phase_done)
  );

  // A new request is only taken while the port is idle.
  assign req_ready_out = (state_ff == ST_IDLE);

  // The last phase of either kind of cycle is ending in this cycle.
  assign cycle_end = phase_done && ((state_ff == ST_READ) || (state_ff == ST_HOLD));

  // Phase sequencing for one cycle at a time.
  always @* begin
    nxt_state    = state_ff;
    nxt_is_write = is_write_ff;
    load         = 1'b0;
    load_cnt     = `ASBP_CNT_ZERO;
    case (state_ff)
      ST_IDLE: begin
        // Only here is a request taken; its first phase is loaded on the same edge.
        if (req_valid_in) begin
          nxt_is_write = req_write_in;
          load         = 1'b1;
          if (req_write_in) begin
            nxt_state = ST_SETUP;
            load_cnt  = cyc(`ASBP_SETUP_CYC);
          end else begin
            nxt_state = ST_READ;
            load_cnt  = cyc(`ASBP_ACCESS_CYC);
          end
        end
      end
      ST_SETUP: begin
        // Address and data settle for one phase with both strobes still high.
        if (phase_done) begin
          nxt_state = ST_PULSE;
          load      = 1'b1;
          load_cnt  = cyc(`ASBP_PULSE_CYC);
        end
      end
      ST_PULSE: begin
        // Both strobes stay low for the whole pulse phase.
        if (phase_done) begin
          nxt_state = ST_HOLD;
          load      = 1'b1;
          load_cnt  = cyc(`ASBP_HOLD_CYC);
        end
      end
      ST_HOLD: begin
        // Select lifts at the end of recovery, which closes a write cycle.
        if (phase_done) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_READ: begin
        // The access window is timed from the edge that dropped select.
        if (phase_done) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // State register; a write keeps its kind until the next request is taken.
  always @(posedge clk_in) begin
    if (rst_in) begin
      state_ff    <= ST_IDLE;
      is_write_ff <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      is_write_ff <= nxt_is_write;
    end
  end

  // Pin drivers come straight from flip-flops so strobes carry no decode glitches.
  // Reset parks every strobe high and frees the bus, so the device sits in standby.
  always @(posedge clk_in) begin
    if (rst_in) begin
      location_lines_out <= {`ASBP_ADDR_W{1'b0}};
      chip_sel_n_out     <= 1'b1;
      write_n_out        <= 1'b1;
      out_en_n_out       <= 1'b1;
      data_out           <= {`ASBP_DATA_W{1'b0}};
      data_oe_n_out      <= 1'b1;
    end else begin
      case (nxt_state)
        ST_IDLE: begin
          chip_sel_n_out <= 1'b1;
          write_n_out    <= 1'b1;
          out_en_n_out   <= 1'b1;
          data_oe_n_out  <= 1'b1;
        end
        ST_SETUP: begin
          // Address and data settle before any strobe falls; output enable stays high.
          location_lines_out <= req_addr_in;
          data_out           <= req_wdata_in;
          data_oe_n_out      <= 1'b0;
          out_en_n_out       <= 1'b1;
          chip_sel_n_out     <= 1'b1;
          write_n_out        <= 1'b1;
        end
        ST_PULSE: begin
          // Both strobes fall together so the device never turns its drivers on.
          chip_sel_n_out <= 1'b0;
          write_n_out    <= 1'b0;
        end
        ST_HOLD: begin
          // Write rises first; select, address and data stay put through recovery.
          write_n_out <= 1'b1;
        end
        ST_READ: begin
          if (state_ff == ST_IDLE) begin
            location_lines_out <= req_addr_in;
          end
          chip_sel_n_out <= 1'b0;
          write_n_out    <= 1'b1;
          out_en_n_out   <= 1'b0;
          data_oe_n_out  <= 1'b1;
        end
        default: begin
          chip_sel_n_out <= 1'b1;
        end
      endcase
    end
  end

  // The answer pulses once as a cycle ends. A read byte is sampled on the edge that
  // lifts the strobes, so it is taken while the device still drives it; a write
  // answer carries no byte and leaves the last read byte in place.
  always @(posedge clk_in) begin
    if (rst_in) begin
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= {`ASBP_DATA_W{1'b0}};
    end else begin
      rsp_valid_out <= cycle_end;
      if (cycle_end && !is_write_ff) begin
        rsp_rdata_out <= data_in;
      end
    end
  end

endmodule

// ### dv/asbp_sram_model.sv
// Behavioural byte-wide static RAM with the shared data bus resolved.
`timescale 1ns/1ps
module asbp_sram_model (
  input  wire        clk_in,
  input  wire        cs_n_in,
  input  wire        we_n_in,
  input  wire        oe_n_in,
  input  wire [10:0] addr_in,
  input  wire [7:0]  host_d_in,
  input  wire        host_oe_n_in,
  output wire [7:0]  bus_out
);
  logic [7:0] mem [0:2047];
  logic [7:0] flt = 8'h5a;
  wire        wr_on = !cs_n_in && !we_n_in;
  wire        rd_on = !cs_n_in && !oe_n_in && we_n_in;
  initial for (int i = 0; i < 2048; i++) mem[i] = ~i[7:0];
  // Latch when the write window closes, so the first strobe to rise wins.
  // Only a window in which the host drives the bus stores, so the reset edge stores nothing.
  always @(negedge wr_on)
    if (host_oe_n_in === 1'b0 && !$isunknown(addr_in)) mem[addr_in] = host_d_in;
  // A released bus moves every cycle, so stale data cannot pass for a read.
  always @(posedge clk_in) flt <= ~flt;
  assign bus_out = !host_oe_n_in ? host_d_in : rd_on ? mem[addr_in] : flt;
endmodule

// ### dv/asbp_host_ctrl_assertions.sv
// Pin protocol checker for the static RAM host controller.
`timescale 1ns/1ps
module asbp_chk (
  input wire        clk_in,
  input wire        rst_in,
  input wire        req_valid_in,
  input wire        req_write_in,
  input wire        req_ready_out,
  input wire        rsp_valid_out,
  input wire [10:0] location_lines_out,
  input wire        chip_sel_n_out,
  input wire        write_n_out,
  input wire        out_en_n_out,
  input wire [7:0]  data_out,
  input wire        data_oe_n_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire take = req_valid_in && req_ready_out;
  AST_STANDBY: assert property (chip_sel_n_out |-> write_n_out && out_en_n_out)
    else $error("strobe active while deselected");
  AST_NO_CLASH: assert property (!data_oe_n_out |-> out_en_n_out)
    else $error("bus clash");
  AST_READ: assert property (take && !req_write_in |=>
    !chip_sel_n_out && !out_en_n_out ##[3:4] rsp_valid_out)
    else $error("read cycle wrong");
  AST_WRITE_TIME: assert property (take && req_write_in |-> ##[5:6] rsp_valid_out)
    else $error("write too slow");
  AST_FALL_TOGETHER: assert property ($fell(write_n_out) |-> $fell(chip_sel_n_out))
    else $error("write strobe leads select");
  AST_PULSE: assert property ($fell(write_n_out) |->
    !write_n_out [*3] ##1 (write_n_out && !chip_sel_n_out))
    else $error("write pulse shape");
  AST_DATA_HOLD: assert property ($rose(write_n_out) |-> !data_oe_n_out && $stable(data_out))
    else $error("data hold lost");
  AST_ADDR: assert property (!chip_sel_n_out && !$past(chip_sel_n_out)
    |-> $stable(location_lines_out))
    else $error("address moved");
  AST_BUSY: assert property (!chip_sel_n_out |-> !req_ready_out)
    else $error("ready while busy");
  AST_OE_READ: assert property (!out_en_n_out |-> write_n_out && !chip_sel_n_out)
    else $error("output enable outside read");
  AST_COV_RD: cover property (take && !req_write_in);
  AST_COV_WR: cover property (take && req_write_in);
  AST_COV_B2B: cover property (rsp_valid_out && take);
endmodule
bind asbp_host_ctrl asbp_chk u_chk (.clk_in(clk_in), .rst_in(rst_in),
  .req_valid_in(req_valid_in), .req_write_in(req_write_in), .req_ready_out(req_ready_out),
  .rsp_valid_out(rsp_valid_out), .location_lines_out(location_lines_out),
  .chip_sel_n_out(chip_sel_n_out), .write_n_out(write_n_out), .out_en_n_out(out_en_n_out),
  .data_out(data_out), .data_oe_n_out(data_oe_n_out));

// ### dv/async_sram_byte_port_tb.sv
// Self-checking bench for the static RAM host controller.
`timescale 1ns/1ps
module async_sram_byte_port_tb;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        req_valid_in = 1'b0;
  logic        req_write_in = 1'b0;
  logic [10:0] req_addr_in = 11'h000;
  logic [7:0]  req_wdata_in = 8'h00;
  logic [7:0]  shadow [0:2047];
  logic [31:0] r;
  int          failures = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  wire         req_ready_out, rsp_valid_out, chip_sel_n_out, write_n_out, out_en_n_out;
  wire         data_oe_n_out;
  wire [7:0]   rsp_rdata_out, data_in, data_out;
  wire [10:0]  location_lines_out;
  asbp_host_ctrl asbp_host_ctrl_i (.clk_in(clk_in), .rst_in(rst_in),
    .req_valid_in(req_valid_in), .req_write_in(req_write_in), .req_addr_in(req_addr_in),
    .req_wdata_in(req_wdata_in), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
    .rsp_rdata_out(rsp_rdata_out), .location_lines_out(location_lines_out),
    .chip_sel_n_out(chip_sel_n_out), .write_n_out(write_n_out), .out_en_n_out(out_en_n_out),
    .data_in(data_in), .data_out(data_out), .data_oe_n_out(data_oe_n_out));
  asbp_sram_model asbp_sram_model_i (.clk_in(clk_in), .cs_n_in(chip_sel_n_out),
    .we_n_in(write_n_out), .oe_n_in(out_en_n_out), .addr_in(location_lines_out),
    .host_d_in(data_out), .host_oe_n_in(data_oe_n_out), .bus_out(data_in));
  initial forever #25 clk_in = ~clk_in;
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // A hung handshake ends the run here; 85 cycles of at most 6 clocks fit well below this.
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      final_report();
    end
  end
  // Contents the RAM holds before any write: the low bits of the location, inverted.
  function automatic logic [7:0] fill_byte(input logic [10:0] a);
    return ~a[7:0];
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One request, held until taken, then wait for its single-cycle answer.
  task automatic xfer(input logic w, input logic [10:0] a, input logic [7:0] d);
    req_valid_in = 1'b1;
    req_write_in = w;
    req_addr_in = a;
    req_wdata_in = d;
    while (!req_ready_out) @(posedge clk_in) #2;
    @(posedge clk_in) #2;
    req_valid_in = 1'b0;
    while (rsp_valid_out !== 1'b1) @(posedge clk_in) #2;
    if (w) shadow[a] = d;
    else chk(rsp_rdata_out, shadow[a]);
  endtask
  initial begin
    for (int i = 0; i < 2048; i++) shadow[i] = fill_byte(i[10:0]);
    void'($urandom(99));
    repeat (10) @(posedge clk_in);
    #2 rst_in = 1'b0;
    chk({5'h00, chip_sel_n_out, write_n_out, out_en_n_out}, 8'h07);
    // Both ends of the location range, plus an untouched neighbour.
    xfer(1'b1, 11'h7ff, 8'ha5);
    xfer(1'b1, 11'h000, 8'h5a);
    xfer(1'b0, 11'h7ff, 8'h00);
    xfer(1'b0, 11'h000, 8'h00);
    xfer(1'b0, 11'h7fe, 8'h00);
    $display("corner test done");
    // A small address pool makes reads land on recent writes.
    repeat (80) begin
      r = $urandom;
      xfer(r[0], {r[20], 6'h00, r[4:1]}, r[19:12]);
    end
    $display("random test done");
    final_report();
  end
endmodule
